/* hdl/adc_batt_regs.sv */
// adc control/status and low-supply control registers of the flash driver
//
// Summary of operation
// - bit 7 of the adc register is a read/write test-mode enable, cleared by reset.
// - bit 6 is a read-only flag that is 1 while the supply is below the armed low threshold.
// - bits 5 to 2 of the adc register return the four-bit conversion result.
// - bits 1 to 0 pick the converter mode: off, led forward voltage, die temperature or external voltage.
// - bit 7 of the low-supply register enables soft peak limiting, set by reset; when clear a peak hit shuts down.
// - bits 6 to 3 hold the read-only low-supply led current code, 1010 after reset.
// - bits 2 to 0 hold the read/write supply threshold, 000 disabling the low-supply function.
`timescale 1ns/10ps
module adc_batt_regs
   import flash_regs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWdata,
   input wire logic regRead,
   output logic [7:0] regRdata,
   input wire logic convDone,
   input wire logic [3:0] convValue,
   input wire logic supplyBelow,
   input wire logic peakLimitHit,
   output logic [1:0] adcMode,
   output logic testModeEn,
   output logic softPeakLimitEn,
   output logic [3:0] lowSupplyLedCurrent,
   output logic [2:0] lowSupplyThreshold,
   output logic lowSupplyActive,
   output logic shutdownReq
);
   import flash_regs_pkg::*;

   typedef struct packed {
      logic testMode;
      logic lowFlag;
      logic [3:0] result;
      adc_mode_t mode;
      logic softLimit;
      logic [3:0] ledCurrent;
      logic [2:0] threshold;
      logic [7:0] rdata;
      logic shutdown;
   } regs_state_t;

   regs_state_t state_q;
   regs_state_t state_d;

   logic [1:0] pinSync;
   logic belowSync;
   logic peakSync;

   logic adcSel;
   logic battSel;
   logic adcWrite;
   logic battWrite;
   logic adcRead;
   logic battRead;

   logic wrTestMode;
   logic [1:0] wrModeCode;
   logic wrSoftLimit;
   logic [2:0] wrThreshold;

   logic thresholdArmed;
   logic measuring;
   logic peakTrip;
   wire logic [7:0] adcView;
   wire logic [7:0] battView;

   // analog comparators are asynchronous to the register clock
   pin_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .asyncIn({supplyBelow, peakLimitHit}),
      .syncOut(pinSync)
   );

   assign belowSync = pinSync[1];
   assign peakSync = pinSync[0];

   // exact address match, anything else is unmapped and reads zero
   assign adcSel = (regAddr == ADC_CTRL_OFFSET);
   assign battSel = (regAddr == BATT_LOW_OFFSET);
   assign adcWrite = regWrite && adcSel;
   assign battWrite = regWrite && battSel;
   assign adcRead = regRead && adcSel;
   assign battRead = regRead && battSel;

   // only the writable fields are picked out of the write data
   assign wrTestMode = regWdata[TEST_MODE_BIT];
   assign wrModeCode = regWdata[MODE_MSB:MODE_LSB];
   assign wrSoftLimit = regWdata[SOFT_LIMIT_BIT];
   assign wrThreshold = regWdata[THRESH_MSB:THRESH_LSB];

   // code 000 leaves the low-supply function off
   assign thresholdArmed = (state_q.threshold != THRESH_DISABLED);
   assign measuring = (state_q.mode != ADC_OFF);
   // only the hard limit setting turns a peak into a shutdown
   assign peakTrip = peakSync && !state_q.softLimit;

   // read image of the adc register
   assign adcView[TEST_MODE_BIT] = state_q.testMode;
   assign adcView[LOW_FLAG_BIT] = state_q.lowFlag;
   assign adcView[RESULT_MSB:RESULT_LSB] = state_q.result;
   assign adcView[MODE_MSB:MODE_LSB] = state_q.mode;

   // read image of the low-supply register
   assign battView[SOFT_LIMIT_BIT] = state_q.softLimit;
   assign battView[LED_CUR_MSB:LED_CUR_LSB] = state_q.ledCurrent;
   assign battView[THRESH_MSB:THRESH_LSB] = state_q.threshold;

   always_comb begin
      state_d = state_q;

      // host writes to the adc register
      if (adcWrite) begin
         state_d.testMode = wrTestMode;
      end
      if (adcWrite) begin
         case (wrModeCode)
            2'b00: begin
               state_d.mode = ADC_OFF;
            end
            2'b01: begin
               state_d.mode = ADC_LED_VF;
            end
            2'b10: begin
               state_d.mode = ADC_DIE_TEMP;
            end
            2'b11: begin
               state_d.mode = ADC_EXT_VOLT;
            end
            default: begin
               state_d.mode = ADC_OFF;
            end
         endcase
      end

      // host writes to the low-supply register
      if (battWrite) begin
         state_d.softLimit = wrSoftLimit;
      end
      if (battWrite) begin
         state_d.threshold = wrThreshold;
      end

      // led current field is read-only, writes leave it alone
      state_d.ledCurrent = RESET_LED_CURRENT;

      // conversions only land while a measurement is selected
      if (convDone && measuring) begin
         state_d.result = convValue;
      end

      // flag is only meaningful with a threshold armed
      if (thresholdArmed) begin
         state_d.lowFlag = belowSync;
      end else begin
         state_d.lowFlag = 1'b0;
      end

      // hard limit latches the shutdown until the host re-enables soft mode
      if (peakTrip) begin
         state_d.shutdown = 1'b1;
      end else if (state_q.softLimit) begin
         state_d.shutdown = 1'b0;
      end

      // read data stands one cycle, then drops back to zero
      if (adcRead) begin
         state_d.rdata = adcView;
      end else if (battRead) begin
         state_d.rdata = battView;
      end else begin
         state_d.rdata = 8'h00;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         // adc register
         state_q.testMode <= RESET_TEST_MODE;
         state_q.lowFlag <= 1'b0;
         state_q.result <= RESET_RESULT;
         state_q.mode <= ADC_OFF;

         // low-supply register
         state_q.softLimit <= RESET_SOFT_LIMIT;
         state_q.ledCurrent <= RESET_LED_CURRENT;
         state_q.threshold <= RESET_THRESHOLD;

         // bus and shutdown
         state_q.rdata <= 8'h00;
         state_q.shutdown <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // bus side
   assign regRdata = state_q.rdata;

   // control outputs to the analog blocks
   assign adcMode = state_q.mode;
   assign testModeEn = state_q.testMode;
   assign softPeakLimitEn = state_q.softLimit;
   assign lowSupplyLedCurrent = state_q.ledCurrent;
   assign lowSupplyThreshold = state_q.threshold;
   assign lowSupplyActive = state_q.lowFlag;
   assign shutdownReq = state_q.shutdown;
endmodule // adc_batt_regs

/* hdl/pin_sync.sv */
// two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_state_t;
   sync_state_t state_q;
   sync_state_t state_d;

   always_comb begin
      state_d.stage1 = asyncIn;
      state_d.stage2 = state_q.stage1;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign syncOut = state_q.stage2;
endmodule // pin_sync

/* pkg/flash_regs_pkg.sv */
// constants and types for the adc and low-supply register pair
package flash_regs_pkg;
   localparam logic [7:0] ADC_CTRL_OFFSET = 8'h08;
   localparam logic [7:0] BATT_LOW_OFFSET = 8'h09;
   localparam int TEST_MODE_BIT = 7;
   localparam int LOW_FLAG_BIT = 6;
   localparam int RESULT_MSB = 5;
   localparam int RESULT_LSB = 2;
   localparam int MODE_MSB = 1;
   localparam int MODE_LSB = 0;
   localparam int SOFT_LIMIT_BIT = 7;
   localparam int LED_CUR_MSB = 6;
   localparam int LED_CUR_LSB = 3;
   localparam int THRESH_MSB = 2;
   localparam int THRESH_LSB = 0;
   localparam logic RESET_TEST_MODE = 1'b0;
   localparam logic RESET_SOFT_LIMIT = 1'b1;
   localparam logic [3:0] RESET_LED_CURRENT = 4'ha;
   localparam logic [2:0] RESET_THRESHOLD = 3'h0;
   localparam logic [3:0] RESET_RESULT = 4'h0;
   localparam logic [2:0] THRESH_DISABLED = 3'h0;
   typedef enum logic [1:0] {
      ADC_OFF = 2'b00,
      ADC_LED_VF = 2'b01,
      ADC_DIE_TEMP = 2'b10,
      ADC_EXT_VOLT = 2'b11
   } adc_mode_t;
endpackage

/* test/adc_batt_regs_chk.sv */
// port assertions for the register pair
`timescale 1ns/10ps
module adc_batt_regs_chk (input logic clk_sys, reset, regWrite, regRead, testModeEn, softPeakLimitEn,
   lowSupplyActive, shutdownReq, input logic [7:0] regAddr, regWdata, regRdata, input logic [1:0] adcMode,
   input logic [2:0] lowSupplyThreshold);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   wire wA = regWrite && regAddr == 8'h08;
   wire wB = regWrite && regAddr == 8'h09;
   wire rA = regRead && !regWrite && regAddr == 8'h08;
   chk_test_bit: assert property (wA |=> testModeEn == $past(regWdata[7])) else $error("test");
   chk_flag_off: assert property (lowSupplyThreshold == 0 && $past(lowSupplyThreshold) == 0 |-> !lowSupplyActive)
      else $error("flag");
   chk_adc_mode: assert property (wA |=> adcMode == $past(regWdata[1:0])) else $error("mode");
   chk_read_back: assert property (rA |=> regRdata[7] == testModeEn && regRdata[1:0] == adcMode)
      else $error("read");
   chk_soft_bit: assert property (wB |=> softPeakLimitEn == $past(regWdata[7])) else $error("soft");
   chk_led_cur: assert property (regRead && regAddr == 8'h09 |=> regRdata[6:3] == 4'ha) else $error("cur");
   chk_thresh: assert property (wB |=> lowSupplyThreshold == $past(regWdata[2:0])) else $error("thr");
   chk_shut_rise: assert property ($rose(shutdownReq) |-> !$past(softPeakLimitEn)) else $error("shut");
   chk_shut_hold: assert property (shutdownReq && !softPeakLimitEn |=> shutdownReq) else $error("hold");
   chk_flag_read: assert property (rA |=> regRdata[6] == $past(lowSupplyActive)) else $error("flagrd");
   chk_rdata_idle: assert property (!regRead |=> regRdata == 8'h00) else $error("idle");
   chk_unmapped_read: assert property (regRead && regAddr != 8'h08 && regAddr != 8'h09 |=> regRdata == 8'h00)
      else $error("unmapped");
endmodule // adc_batt_regs_chk
bind adc_batt_regs adc_batt_regs_chk chk (.*);

/* test/adc_batt_regs_tb.sv */
// random and corner-case bench for the register pair
`timescale 1ns/10ps
module adc_batt_regs_tb;
   logic clk_sys = 0, reset = 1, regWrite = 0, regRead = 0, supplyBelow = 0, peakLimitHit = 0, convDone;
   logic testModeEn, softPeakLimitEn, lowSupplyActive, shutdownReq;
   logic [7:0] regAddr = 0, regWdata = 0, regRdata, r, w;
   logic [3:0] convValue, lowSupplyLedCurrent, sample = 0;
   logic [2:0] lowSupplyThreshold;
   logic [1:0] adcMode;
   int num_errors = 0, n_checks = 0, seed = 32'h28e0;
   adc_batt_regs uut (.*);
   conv_model conv (.*);
   initial forever #4 clk_sys = ~clk_sys;
   function automatic logic [7:0] exp09(input logic [7:0] d); return {d[7], 4'ha, d[2:0]}; endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      num_errors += (g !== e);
      if (g !== e) $display("Error %0t %h %h", $time, g, e);
   endtask
   task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic we);
      {regAddr, regWdata} <= {a, d};
      {regWrite, regRead} <= {we, !we};
      @(posedge clk_sys) {regWrite, regRead} <= 2'h0;
      #1 r = regRdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      acc(a, 8'h00, 1'b0);
      chk(r, e);
   endtask
   task automatic final_report;
      if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      rc(8'h08, 8'h00);
      rc(8'h09, 8'hd0);
      repeat (20) begin
         w = 8'($random(seed));
         supplyBelow <= w[4];
         acc(8'h09, w | 8'h80, 1'b1);
         acc(8'h08, w, 1'b1);
         rc(8'h09, exp09(w | 8'h80));
         acc(8'h08, 8'h00, 1'b0);
         chk(r & 8'hc3, {w[7], w[4] && w[2:0] != 0, 4'h0, w[1:0]});
         chk({4'h0, lowSupplyLedCurrent}, 8'h0a);
         chk({5'h0, lowSupplyThreshold}, {5'h0, w[2:0]});
         chk({7'h0, lowSupplyActive}, {7'h0, w[4] && w[2:0] != 0});
         chk({testModeEn, softPeakLimitEn, 4'h0, adcMode}, {w[7], 1'b1, 4'h0, w[1:0]});
      end
      supplyBelow <= 1'b0;
      for (int m = 1; m < 5; m++) begin
         acc(8'h08, 8'(m % 4), 1'b1);
         sample <= 4'(m * 3);
         repeat (12) @(posedge clk_sys);
         rc(8'h08, {2'h0, 4'(m < 4 ? m * 3 : 9), 2'(m % 4)});
      end
      acc(8'h09, 8'h05, 1'b1);
      acc(8'h0a, 8'hff, 1'b1);
      rc(8'h09, 8'h55);
      peakLimitHit <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk({7'h0, shutdownReq}, 8'h01);
      acc(8'h09, 8'h80, 1'b1);
      repeat (2) @(posedge clk_sys);
      chk({7'h0, shutdownReq}, 8'h00);
      final_report;
   end
endmodule // adc_batt_regs_tb

/* test/conv_model.sv */
// converter model: a fresh sample every eight cycles while a mode is set
`timescale 1ns/10ps
module conv_model (input wire logic clk_sys, input wire logic [1:0] adcMode, input wire logic [3:0] sample,
   output logic convDone, output logic [3:0] convValue);
   logic [2:0] cnt = 3'h0;
   always @(posedge clk_sys) cnt <= cnt + 3'h1;
   assign convDone = adcMode != 2'h0 && cnt == 3'h7;
   // value only holds with the pulse, so a stale read shows up
   assign convValue = convDone ? sample : ~sample;
endmodule // conv_model
